// File: hw/tlb_err_pkg.sv
`default_nettype none
package tlb_err_pkg;
  localparam logic [15:0] ERROR_FEATURE_OFS = 16'h8E80;
  localparam logic [15:0] ERROR_CONTROL_OFS = 16'h8E88;
  localparam logic [15:0] ERROR_SYNDROME_OFS = 16'h8E90;
  localparam logic [15:0] IRQ_STATUS_OFS = 16'h8EA0;
  localparam logic [15:0] IRQ_ENABLE_OFS = 16'h8EA4;
  localparam logic [15:0] IRQ_CLEAR_OFS = 16'h8EA8;
  localparam logic [15:0] ERROR_INJECTION_OFS = 16'h8EC0;
  localparam logic [15:0] SECURE_CONTROL_OFS = 16'h8E18;
  localparam logic [15:0] GATED_LOW_OFS = 16'h8E80;
  localparam logic [15:0] GATED_HIGH_OFS = 16'h8EC0;

  localparam logic [31:0] ERROR_FEATURE_VAL = 32'h0000_0081;
  localparam int FEAT_IRQ_LSB = 6;
  localparam int FEAT_DET_LSB = 0;
  localparam logic [1:0] FEAT_IRQ_CTRL = 2'h2;
  localparam logic [1:0] FEAT_DET_ALWAYS = 2'h1;

  localparam int CTRL_IRQ_EN_BIT = 3;
  localparam logic CTRL_IRQ_EN_RST = 1'b1;
  localparam int SCR_NS_BIT = 1;
  localparam int STS_VALID_BIT = 30;
  localparam int STS_OVF_BIT = 27;
  localparam int STS_CE_LSB = 24;
  localparam int STS_CODE_LSB = 0;
  localparam int INJ_TAG_BIT = 1;
  localparam int INJ_DATA_BIT = 0;
  localparam int IRQ_REC_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;

  localparam logic [1:0] CE_NONE = 2'h0;
  localparam logic [1:0] CE_CORRECTED = 2'h2;
  localparam logic [1:0] CE_CLEAR_KEY = 2'h3;
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_TAG = 8'h07;
  localparam logic [7:0] CODE_DATA = 8'h08;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef struct packed {
    logic ap_valid;
    logic ap_write;
    logic ap_nonsec;
    logic [15:0] ap_addr;
    logic fault_irq_enable;
    logic nonsecure_error_reg_access;
    logic record_valid;
    logic record_overflow;
    logic [1:0] corrected_error;
    logic [7:0] error_code;
    logic inject_tag_parity;
    logic inject_data_parity;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic irq;
    logic ras_irq;
    logic [31:0] hrdata;
  } regs_s;
endpackage : tlb_err_pkg
`default_nettype wire

// File: hw/tlb_error_record_regs.sv
// Behaviour
// - Feature bits 7:6 read 0b10, read-only.
// - Feature bits 1:0 read 0b01.
// - Control bit 3 enables fault interrupt output.
// - Non-secure access gated: reads zero, writes ignored.
// - Valid flag set when error recorded.
// - Write-one clears valid unless CE remains.
// - Overflow set on error while CE nonzero.
// - Write-one clears overflow; zero ignored.
// - Recorded corrected error sets CE to 0b10.
// - Writing 0b11 clears CE unless overflow remains.
// - Code 0x07 tag, 0x08 data, zero without CE.
// - Writes to error code ignored.
// - Each unit instance holds own control, status.
// - Injection bit 1 corrupts written tag parity.
// - Injection bit 0 corrupts written data parity.
// - Secure control bit 1 gates non-secure access.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`default_nettype none
module tlb_error_record_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hnonsec,
  input wire logic tag_parity_fault,
  input wire logic data_parity_fault,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic [1:0] hresp,
  output logic inject_tag_parity,
  output logic inject_data_parity,
  output logic ras_irq,
  output logic irq
);

  // Each instance owns its record, so several units never share status.
  tlb_err_pkg::regs_s st_r;
  tlb_err_pkg::regs_s st_nxt;
  logic hreadyout_r;

  function automatic logic gated_range(input logic [15:0] a);
    gated_range = (a >= tlb_err_pkg::GATED_LOW_OFS) &&
                  (a <= tlb_err_pkg::GATED_HIGH_OFS);
  endfunction : gated_range

  // Non-secure access is refused for the error range unless enabled, and
  // the secure control word itself is never reachable from non-secure.
  function automatic logic access_ok(input logic [15:0] a,
                                     input logic ns,
                                     input logic ns_ok);
    if (!ns) begin
      access_ok = 1'b1;
    end else if (a == tlb_err_pkg::SECURE_CONTROL_OFS) begin
      access_ok = 1'b0;
    end else if (gated_range(a)) begin
      access_ok = ns_ok;
    end else begin
      access_ok = 1'b1;
    end
  endfunction : access_ok

  function automatic logic [31:0] read_mux(input tlb_err_pkg::regs_s s,
                                           input logic [15:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      tlb_err_pkg::ERROR_FEATURE_OFS: begin
        d = tlb_err_pkg::ERROR_FEATURE_VAL;
        d[tlb_err_pkg::FEAT_IRQ_LSB +: 2] = tlb_err_pkg::FEAT_IRQ_CTRL;
        d[tlb_err_pkg::FEAT_DET_LSB +: 2] = tlb_err_pkg::FEAT_DET_ALWAYS;
      end
      tlb_err_pkg::ERROR_CONTROL_OFS: begin
        d[tlb_err_pkg::CTRL_IRQ_EN_BIT] = s.fault_irq_enable;
      end
      tlb_err_pkg::ERROR_SYNDROME_OFS: begin
        d[tlb_err_pkg::STS_VALID_BIT] = s.record_valid;
        d[tlb_err_pkg::STS_OVF_BIT] = s.record_overflow;
        d[tlb_err_pkg::STS_CE_LSB +: 2] = s.corrected_error;
        d[tlb_err_pkg::STS_CODE_LSB +: 8] = s.error_code;
      end
      tlb_err_pkg::IRQ_STATUS_OFS: begin
        d[1:0] = s.irq_status;
      end
      tlb_err_pkg::IRQ_ENABLE_OFS: begin
        d[1:0] = s.irq_enable;
      end
      tlb_err_pkg::ERROR_INJECTION_OFS: begin
        d[tlb_err_pkg::INJ_TAG_BIT] = s.inject_tag_parity;
        d[tlb_err_pkg::INJ_DATA_BIT] = s.inject_data_parity;
      end
      tlb_err_pkg::SECURE_CONTROL_OFS: begin
        d[tlb_err_pkg::SCR_NS_BIT] = s.nonsecure_error_reg_access;
      end
      default: begin
        d = 32'h0000_0000;
      end
    endcase
    read_mux = d;
  endfunction : read_mux

  logic wr_dp;
  logic wr_ok;
  logic rec_event;
  logic ovf_event;
  logic ovf_clearing;
  logic ce_clearing;
  logic v_clearing;
  logic rd_take;

  always_comb begin
    st_nxt = st_r;
    wr_dp = st_r.ap_valid && st_r.ap_write;
    wr_ok = wr_dp && access_ok(st_r.ap_addr, st_r.ap_nonsec,
                               st_r.nonsecure_error_reg_access);
    ovf_clearing = 1'b0;
    ce_clearing = 1'b0;
    v_clearing = 1'b0;
    rec_event = 1'b0;
    ovf_event = 1'b0;
    if (wr_ok) begin
      case (st_r.ap_addr)
        tlb_err_pkg::ERROR_CONTROL_OFS: begin
          st_nxt.fault_irq_enable = hwdata[tlb_err_pkg::CTRL_IRQ_EN_BIT];
        end
        tlb_err_pkg::ERROR_SYNDROME_OFS: begin
          // Clears are judged against the old flags, so a flag that is
          // set and not cleared in the same write blocks its partner.
          ovf_clearing = hwdata[tlb_err_pkg::STS_OVF_BIT];
          ce_clearing = (hwdata[tlb_err_pkg::STS_CE_LSB +: 2] ==
                         tlb_err_pkg::CE_CLEAR_KEY) &&
                        !(st_r.record_overflow && !ovf_clearing);
          v_clearing = hwdata[tlb_err_pkg::STS_VALID_BIT] &&
                       !((st_r.corrected_error != tlb_err_pkg::CE_NONE) &&
                         !ce_clearing);
          // The code field takes no write data at all.
          if (ovf_clearing) begin
            st_nxt.record_overflow = 1'b0;
          end
          if (ce_clearing) begin
            st_nxt.corrected_error = tlb_err_pkg::CE_NONE;
            st_nxt.error_code = tlb_err_pkg::CODE_NONE;
          end
          if (v_clearing) begin
            st_nxt.record_valid = 1'b0;
          end
        end
        tlb_err_pkg::IRQ_ENABLE_OFS: begin
          st_nxt.irq_enable = hwdata[1:0];
        end
        tlb_err_pkg::IRQ_CLEAR_OFS: begin
          st_nxt.irq_status = st_r.irq_status & ~hwdata[1:0];
        end
        tlb_err_pkg::ERROR_INJECTION_OFS: begin
          st_nxt.inject_tag_parity = hwdata[tlb_err_pkg::INJ_TAG_BIT];
          st_nxt.inject_data_parity = hwdata[tlb_err_pkg::INJ_DATA_BIT];
        end
        tlb_err_pkg::SECURE_CONTROL_OFS: begin
          st_nxt.nonsecure_error_reg_access = hwdata[tlb_err_pkg::SCR_NS_BIT];
        end
        default: begin
          st_nxt.irq_enable = st_nxt.irq_enable;
        end
      endcase
    end
    // Recording runs after the clears so that a fault arriving with a
    // clear is kept. A tag fault wins when both strike at once because
    // it hides the data fault anyway.
    if (tag_parity_fault || data_parity_fault) begin
      rec_event = 1'b1;
      st_nxt.record_valid = 1'b1;
      if (st_nxt.corrected_error != tlb_err_pkg::CE_NONE) begin
        st_nxt.record_overflow = 1'b1;
        ovf_event = 1'b1;
      end else begin
        st_nxt.corrected_error = tlb_err_pkg::CE_CORRECTED;
        st_nxt.error_code = tag_parity_fault ? tlb_err_pkg::CODE_TAG :
                            tlb_err_pkg::CODE_DATA;
      end
    end
    if (rec_event) begin
      st_nxt.irq_status[tlb_err_pkg::IRQ_REC_BIT] = 1'b1;
    end
    if (ovf_event) begin
      st_nxt.irq_status[tlb_err_pkg::IRQ_OVF_BIT] = 1'b1;
    end
    st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_enable);
    st_nxt.ras_irq = st_nxt.fault_irq_enable && st_nxt.record_valid;
    // Address phase; reads sample the updated state to see prior writes.
    rd_take = hsel && hready && (htrans == tlb_err_pkg::HTRANS_NONSEQ ||
                                 htrans == 2'h3);
    st_nxt.ap_valid = rd_take;
    st_nxt.ap_write = hwrite;
    st_nxt.ap_nonsec = hnonsec;
    st_nxt.ap_addr = {haddr[15:2], 2'h0};
    st_nxt.hrdata = 32'h0000_0000;
    if (rd_take && !hwrite &&
        access_ok({haddr[15:2], 2'h0}, hnonsec,
                  st_nxt.nonsecure_error_reg_access)) begin
      st_nxt.hrdata = read_mux(st_nxt, {haddr[15:2], 2'h0});
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.fault_irq_enable <= tlb_err_pkg::CTRL_IRQ_EN_RST;
      hreadyout_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      hreadyout_r <= 1'b1;
    end
  end

  // The slave never inserts wait states and never signals an error.
  assign hreadyout = hreadyout_r;
  assign hresp = tlb_err_pkg::HRESP_OKAY;
  assign hrdata = st_r.hrdata;
  assign inject_tag_parity = st_r.inject_tag_parity;
  assign inject_data_parity = st_r.inject_data_parity;
  assign ras_irq = st_r.ras_irq;
  assign irq = st_r.irq;

  logic any_fault;
  logic sts_wr;
  assign any_fault = tag_parity_fault || data_parity_fault;
  assign sts_wr = wr_dp &&
                  st_r.ap_addr == tlb_err_pkg::ERROR_SYNDROME_OFS;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_feature_read;
    hsel && hready && htrans == tlb_err_pkg::HTRANS_NONSEQ && !hwrite &&
    !hnonsec && haddr[15:0] == tlb_err_pkg::ERROR_FEATURE_OFS
    |=> hrdata == 32'h0000_0081;
  endproperty
  a_feature_read: assert property (p_feature_read)
    else $error("feature register read wrong value");

  property p_ns_write_ignored;
    wr_dp && st_r.ap_nonsec && !st_r.nonsecure_error_reg_access &&
    st_r.ap_addr == tlb_err_pkg::ERROR_CONTROL_OFS
    |=> $stable(st_r.fault_irq_enable);
  endproperty
  a_ns_write_ignored: assert property (p_ns_write_ignored)
    else $error("gated non-secure write changed control");

  property p_first_record;
    any_fault && st_r.corrected_error == 2'h0 && !sts_wr
    |=> st_r.record_valid && st_r.corrected_error == 2'h2 &&
        !st_r.record_overflow ##1 (st_r.record_valid || $past(sts_wr));
  endproperty
  a_first_record: assert property (p_first_record)
    else $error("record not captured");

  property p_overflow_set;
    any_fault && st_r.corrected_error != 2'h0 && !sts_wr
    |=> st_r.record_overflow && $stable(st_r.error_code);
  endproperty
  a_overflow_set: assert property (p_overflow_set)
    else $error("overflow not set on second error");

  property p_valid_held;
    sts_wr && st_r.ap_nonsec == 1'b0 && st_r.record_valid &&
    st_r.corrected_error != 2'h0 && hwdata[25:24] != 2'h3
    |=> st_r.record_valid;
  endproperty
  a_valid_held: assert property (p_valid_held)
    else $error("valid cleared while CE still set");

  property p_ce_held_by_of;
    sts_wr && !st_r.ap_nonsec && st_r.record_overflow &&
    !hwdata[27] && st_r.corrected_error != 2'h0
    |=> st_r.corrected_error != 2'h0;
  endproperty
  a_ce_held_by_of: assert property (p_ce_held_by_of)
    else $error("CE cleared while overflow kept");

  property p_code_consistent;
    (st_r.corrected_error == 2'h0) ? (st_r.error_code == 8'h00) :
    (st_r.error_code == 8'h07 || st_r.error_code == 8'h08);
  endproperty
  a_code_consistent: assert property (p_code_consistent)
    else $error("error code inconsistent with CE");

  property p_ras_irq;
    $rose(st_r.record_valid) && st_r.fault_irq_enable
    |-> ras_irq ##1 (ras_irq || !st_r.record_valid ||
                     !st_r.fault_irq_enable);
  endproperty
  a_ras_irq: assert property (p_ras_irq)
    else $error("fault interrupt did not follow record");

  property p_no_ras_irq;
    !st_r.fault_irq_enable |-> !ras_irq;
  endproperty
  a_no_ras_irq: assert property (p_no_ras_irq)
    else $error("fault interrupt while disabled");

  property p_inject_write;
    wr_dp && !st_r.ap_nonsec &&
    st_r.ap_addr == tlb_err_pkg::ERROR_INJECTION_OFS
    |=> inject_tag_parity == $past(hwdata[1]) &&
        inject_data_parity == $past(hwdata[0]);
  endproperty
  a_inject_write: assert property (p_inject_write)
    else $error("injection outputs not updated");

  property p_of_clear;
    sts_wr && !st_r.ap_nonsec && hwdata[27] && !any_fault
    |=> !st_r.record_overflow;
  endproperty
  a_of_clear: assert property (p_of_clear)
    else $error("overflow not cleared by write one");

  // A fault that meets a clear in one cycle must survive it, or the new
  // error would vanish without trace.
  property p_set_wins;
    any_fault |=> st_r.record_valid &&
                  st_r.irq_status[tlb_err_pkg::IRQ_REC_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("fault lost against a clear in the same cycle");

  property p_clear_then_record;
    sts_wr && !st_r.ap_nonsec && !st_r.record_overflow &&
    hwdata[tlb_err_pkg::STS_CE_LSB +: 2] == tlb_err_pkg::CE_CLEAR_KEY &&
    data_parity_fault && !tag_parity_fault
    |=> st_r.error_code == tlb_err_pkg::CODE_DATA &&
        !st_r.record_overflow;
  endproperty
  a_clear_then_record: assert property (p_clear_then_record)
    else $error("new record wrong after clear in same cycle");

  c_record: cover property (any_fault ##1 st_r.record_valid);
  c_overflow: cover property ($rose(st_r.record_overflow));
  c_clear_all: cover property ($fell(st_r.record_valid));
  c_irq: cover property ($rose(irq));

endmodule : tlb_error_record_regs
`default_nettype wire

// File: tb/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hnonsec = 1'b0;
  logic tag_fault = 1'b0;
  logic data_fault = 1'b0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic [1:0] hresp;
  logic inj_tag;
  logic inj_data;
  logic ras_irq;
  logic irq;
  logic [31:0] rd;
  int fails = 0;
  int n_compared = 0;

  initial begin
    forever #4 hclk = ~hclk;
  end

  // Single slave on the bus, so its own ready is the bus ready.
  tlb_error_record_regs dut_u (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hnonsec(hnonsec),
    .tag_parity_fault(tag_fault),
    .data_parity_fault(data_fault),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .inject_tag_parity(inj_tag),
    .inject_data_parity(inj_data),
    .ras_irq(ras_irq),
    .irq(irq)
  );

  task automatic finish_test();
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Ready is looked at half a cycle early, where it is settled.
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(negedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (hreadyout !== 1'b1) begin
      fails++;
      finish_test();
    end
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic ns, input logic [15:0] ofs,
                      input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= tlb_err_pkg::HTRANS_NONSEQ;
    haddr <= {16'h0000, ofs};
    hwrite <= w;
    hnonsec <= ns;
    wait_rdy();
    @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check({30'h0, hresp}, 32'h0);
    @(posedge hclk);
  endtask : xfer

  task automatic wr(input logic ns, input logic [15:0] ofs,
                    input logic [31:0] d);
    xfer(1'b1, ns, ofs, d);
  endtask : wr

  task automatic rdchk(input logic ns, input logic [15:0] ofs,
                       input logic [31:0] e);
    xfer(1'b0, ns, ofs, 32'h0);
    check(rd, e);
  endtask : rdchk

  // Expected order is ras_irq, irq, tag injection, data injection.
  task automatic outs(input logic [3:0] e);
    @(negedge hclk);
    check({28'h0, ras_irq, irq, inj_tag, inj_data}, {28'h0, e});
    @(posedge hclk);
  endtask : outs

  task automatic fault(input logic t, input logic d);
    tag_fault <= t;
    data_fault <= d;
    @(posedge hclk);
    tag_fault <= 1'b0;
    data_fault <= 1'b0;
  endtask : fault

  task automatic t_reset();
    rdchk(0, tlb_err_pkg::ERROR_FEATURE_OFS, 32'h0000_0081);
    rdchk(0, tlb_err_pkg::ERROR_CONTROL_OFS, 32'h0000_0008);
    rdchk(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h0);
    rdchk(0, tlb_err_pkg::ERROR_INJECTION_OFS, 32'h0);
    outs(4'h0);
    wr(0, tlb_err_pkg::ERROR_FEATURE_OFS, 32'hFFFF_FFFF);
    rdchk(0, tlb_err_pkg::ERROR_FEATURE_OFS, 32'h0000_0081);
    wr(0, 16'h8E84, 32'h1234_5678);
    rdchk(0, 16'h8E84, 32'h0);
  endtask : t_reset

  task automatic t_secure();
    wr(1, tlb_err_pkg::ERROR_CONTROL_OFS, 32'h0);
    rdchk(1, tlb_err_pkg::ERROR_CONTROL_OFS, 32'h0);
    rdchk(0, tlb_err_pkg::ERROR_CONTROL_OFS, 32'h0000_0008);
    rdchk(1, tlb_err_pkg::ERROR_FEATURE_OFS, 32'h0);
    rdchk(1, tlb_err_pkg::ERROR_INJECTION_OFS, 32'h0);
    wr(1, tlb_err_pkg::SECURE_CONTROL_OFS, 32'h2);
    rdchk(1, tlb_err_pkg::ERROR_FEATURE_OFS, 32'h0);
    wr(0, tlb_err_pkg::SECURE_CONTROL_OFS, 32'h2);
    rdchk(1, tlb_err_pkg::ERROR_FEATURE_OFS, 32'h0000_0081);
    rdchk(1, tlb_err_pkg::ERROR_CONTROL_OFS, 32'h0000_0008);
    wr(0, tlb_err_pkg::SECURE_CONTROL_OFS, 32'h0);
    rdchk(1, tlb_err_pkg::ERROR_CONTROL_OFS, 32'h0);
  endtask : t_secure

  task automatic t_record();
    fault(1'b1, 1'b0);
    rdchk(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h4200_0007);
    outs(4'h8);
    fault(1'b0, 1'b1);
    rdchk(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h4A00_0007);
    wr(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h4000_0000);
    rdchk(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h4A00_0007);
    wr(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h0300_0000);
    rdchk(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h4A00_0007);
    wr(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h0100_00FF);
    rdchk(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h4A00_0007);
    wr(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h0800_0000);
    rdchk(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h4200_0007);
    outs(4'h8);
    wr(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h4300_0000);
    rdchk(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h0);
    outs(4'h0);
  endtask : t_record

  task automatic t_irq();
    wr(0, tlb_err_pkg::ERROR_CONTROL_OFS, 32'h0);
    fault(1'b0, 1'b1);
    rdchk(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h4200_0008);
    outs(4'h0);
    rdchk(0, tlb_err_pkg::IRQ_STATUS_OFS, 32'h3);
    wr(0, tlb_err_pkg::IRQ_ENABLE_OFS, 32'h1);
    outs(4'h4);
    wr(0, tlb_err_pkg::IRQ_CLEAR_OFS, 32'h1);
    rdchk(0, tlb_err_pkg::IRQ_STATUS_OFS, 32'h2);
    outs(4'h0);
    wr(0, tlb_err_pkg::IRQ_ENABLE_OFS, 32'h3);
    outs(4'h4);
    wr(0, tlb_err_pkg::IRQ_CLEAR_OFS, 32'h3);
    rdchk(0, tlb_err_pkg::IRQ_STATUS_OFS, 32'h0);
    outs(4'h0);
    wr(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h4300_0000);
    wr(0, tlb_err_pkg::ERROR_CONTROL_OFS, 32'h8);
    rdchk(0, tlb_err_pkg::ERROR_CONTROL_OFS, 32'h8);
  endtask : t_irq

  // Both injection bits are never set together, as a masked data error
  // would go unseen.
  task automatic t_inject();
    wr(0, tlb_err_pkg::ERROR_INJECTION_OFS, 32'h2);
    outs(4'h2);
    rdchk(0, tlb_err_pkg::ERROR_INJECTION_OFS, 32'h2);
    wr(0, tlb_err_pkg::ERROR_INJECTION_OFS, 32'h1);
    outs(4'h1);
    wr(0, tlb_err_pkg::ERROR_INJECTION_OFS, 32'h0);
    outs(4'h0);
  endtask : t_inject

  // A fault in the data phase of a full clear must leave a fresh record
  // behind, since the set wins over the clear.
  task automatic t_race();
    fault(1'b1, 1'b0);
    hsel <= 1'b1;
    htrans <= tlb_err_pkg::HTRANS_NONSEQ;
    haddr <= {16'h0000, tlb_err_pkg::ERROR_SYNDROME_OFS};
    hwrite <= 1'b1;
    hnonsec <= 1'b0;
    wait_rdy();
    @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= 32'h4300_0000;
    data_fault <= 1'b1;
    wait_rdy();
    @(posedge hclk);
    data_fault <= 1'b0;
    rdchk(0, tlb_err_pkg::ERROR_SYNDROME_OFS, 32'h4200_0008);
    outs(4'hC);
  endtask : t_race

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_secure();
    t_record();
    t_irq();
    t_inject();
    t_race();
    finish_test();
  end
endmodule : tb
`default_nettype wire
